// ===== design/event_irq_pkg.sv
package event_irq_pkg;

  // --------------------------------------------------------------------
  // Clock and debounce times.
  // --------------------------------------------------------------------
  localparam real CLK_MHZ      = 200.0;  // Core clock rate in MHz.
  localparam real LOWV_DEB_MS  = 3.9;    // Low supply debounce in ms.
  localparam real BTN_DEB_MS   = 31.25;  // Button debounce in ms.
  localparam real TEMP_DEB_MS  = 3.9;    // Temperature debounce in ms.
  localparam real OC_DEB_MS    = 8.0;    // Overcurrent and fuse debounce in ms.
  // Least times round up; the small offset absorbs floating point noise.
  localparam int  LOWV_DEB_CYC = int'($ceil(LOWV_DEB_MS * CLK_MHZ * 1000.0 - 0.001));
  localparam int  BTN_DEB_CYC  = int'($ceil(BTN_DEB_MS * CLK_MHZ * 1000.0 - 0.001));
  localparam int  TEMP_DEB_CYC = int'($ceil(TEMP_DEB_MS * CLK_MHZ * 1000.0 - 0.001));
  localparam int  OC_DEB_CYC   = int'($ceil(OC_DEB_MS * CLK_MHZ * 1000.0 - 0.001));

  // --------------------------------------------------------------------
  // Register offsets.
  // --------------------------------------------------------------------
  localparam logic [7:0] EVENT_STATUS_A_OFS = 8'h05;
  localparam logic [7:0] EVENT_MASK_A_OFS   = 8'h06;
  localparam logic [7:0] EVENT_LEVEL_A_OFS  = 8'h07;
  localparam logic [7:0] EVENT_STATUS_B_OFS = 8'h08;
  localparam logic [7:0] EVENT_MASK_B_OFS   = 8'h09;
  localparam logic [7:0] EVENT_LEVEL_B_OFS  = 8'h0A;
  localparam logic [7:0] EVENT_STATUS_C_OFS = 8'h0E;
  localparam logic [7:0] EVENT_MASK_C_OFS   = 8'h0F;
  localparam logic [7:0] EVENT_LEVEL_C_OFS  = 8'h10;
  localparam logic [7:0] EVENT_STATUS_D_OFS = 8'h11;
  localparam logic [7:0] EVENT_MASK_D_OFS   = 8'h12;
  localparam logic [7:0] EVENT_LEVEL_D_OFS  = 8'h13;

  // --------------------------------------------------------------------
  // Event indices and field positions.
  // --------------------------------------------------------------------
  localparam int NUM_EV      = 14;  // Debounced events.
  localparam int NUM_IN      = 15;  // Synchronised inputs, events plus supply pin.
  localparam int EV_BUTTON   = 0;   // Button, both edges.
  localparam int EV_LOW_SUP  = 1;   // Low supply, active when below threshold.
  localparam int EV_TEMP_LO  = 2;   // First of four temperature trips.
  localparam int EV_TEMP_HI  = 5;   // Last of four temperature trips.
  localparam int EV_BUCK_LO  = 6;   // First of five buck overloads.
  localparam int EV_BOOST    = 11;  // Boost overload.
  localparam int EV_FUSE     = 12;  // Fuse memory error.
  localparam int EV_LDO_ONE  = 13;  // First linear regulator overload.
  localparam int IN_PROG_SUP = 14;  // Programming supply level, no event.
  localparam int PROG_SUP_BIT = 7;  // Position of supply level in level A.
  localparam int FUSE_BIT     = 7;  // Position of fuse error in group C.

  // --------------------------------------------------------------------
  // Reset values.
  // --------------------------------------------------------------------
  localparam logic [NUM_EV-1:0] STATUS_RST   = '0;
  localparam logic [NUM_EV-1:0] MASK_RST     = '1;
  localparam logic [1:0]        MASK_B_RSV_RST = 2'h3;

  // Raw event inputs; bit order matches the event indices.
  typedef struct packed {
    logic       prog_supply_pin;  // High when tied to the core supply.
    logic       ldo_one_oc;       // Linear regulator above current limit.
    logic       fuse_error;       // One or two bit fuse error found.
    logic       boost_oc;         // Boost above current limit.
    logic [4:0] buck_oc;          // Bucks 1A, 1B, 2, 3A, 3B, low bit first.
    logic [3:0] temp_trip;        // Above 110, 120, 125, 130 degrees.
    logic       supply_ok;        // High while input supply is above threshold.
    logic       power_button_in;  // Button pin level.
  } event_in_t;

  // Register port from the serial protocol engine.
  typedef struct packed {
    logic       wr_en;  // One-cycle write strobe.
    logic       rd_en;  // One-cycle read strobe.
    logic [7:0] addr;   // Register offset.
    logic [7:0] wdata;  // Write data.
  } reg_req_t;

endpackage

// ===== design/event_irq_ctrl.sv
module event_irq_ctrl #(
  parameter int LOWV_CYC = event_irq_pkg::LOWV_DEB_CYC,  // Low supply debounce.
  parameter int BTN_CYC  = event_irq_pkg::BTN_DEB_CYC,   // Button debounce.
  parameter int TEMP_CYC = event_irq_pkg::TEMP_DEB_CYC,  // Temperature debounce.
  parameter int OC_CYC   = event_irq_pkg::OC_DEB_CYC     // Overcurrent debounce.
) (
  input  wire logic                    clk,
  input  wire logic                    rst_b,
  input  wire event_irq_pkg::event_in_t ev_in,
  input  wire logic [1:0]              button_debounce_sel,
  input  wire event_irq_pkg::reg_req_t reg_req,
  output logic [7:0]                   reg_rdata,
  output logic                         irq_out_n
);
  import event_irq_pkg::*;

  // --------------------------------------------------------------------
  // State.
  // --------------------------------------------------------------------
  logic [NUM_IN-1:0] s1_r, s2_r, s3_r;        // Three-stage input synchroniser.
  logic [NUM_IN-1:0] lvl_r, lvl_nxt;          // Agreed live levels.
  logic [NUM_EV-1:0] seen_r, seen_nxt;        // Input has settled once.
  logic [NUM_EV-1:0] deb_r, deb_nxt;          // Debounced levels.
  logic [31:0]       cnt_r [NUM_EV];          // Stability counters.
  logic [31:0]       cnt_nxt [NUM_EV];
  logic [NUM_EV-1:0] set_ev;                  // One-cycle event pulses.
  logic [NUM_EV-1:0] st_r, st_nxt;            // Latched flags.
  logic [NUM_EV-1:0] mk_r, mk_nxt;            // Mask bits.
  logic [1:0]        mkrsv_r, mkrsv_nxt;      // Reserved mask B bits 2 and 6.
  logic [7:0]        rdata_r, rdata_nxt;      // Read data register.
  logic              irq_n_r, irq_n_nxt;      // Interrupt pin register.
  logic [NUM_IN-1:0] raw;                     // Inputs with low supply inverted.
  logic [2:0]        warm_r, warm_nxt;        // Fills with ones as the synchroniser primes.

  // Low supply is carried as "below threshold" so that its level reads 1 when low.
  assign raw = {ev_in[NUM_IN-1:2], ~ev_in.supply_ok, ev_in.power_button_in};

  // --------------------------------------------------------------------
  // Helper functions.
  // --------------------------------------------------------------------
  // Places five regulator bits at 0, 1, 3, 4, 5 of a group B byte.
  function automatic logic [7:0] pack_b(input logic [4:0] v);
    pack_b = {2'b00, v[4:2], 1'b0, v[1:0]};
  endfunction

  // Pulls the five regulator bits out of a group B byte.
  function automatic logic [4:0] unpack_b(input logic [7:0] d);
    unpack_b = {d[5:3], d[1:0]};
  endfunction

  // Stability time for event i entering level rise under the given select.
  function automatic logic [31:0] deb_limit(input int i, input logic rise,
                                            input logic [1:0] sel);
    logic [31:0] base;
    // Overcurrent and fuse events take the plain long time.
    base = 32'(OC_CYC);
    if (i == EV_BUTTON) begin
      base = rise ? 32'(BTN_CYC) : (32'(BTN_CYC) << sel);
    end else if (i == EV_LOW_SUP) begin
      base = rise ? (32'(LOWV_CYC) << sel) : 32'(LOWV_CYC);
    end else if (i >= EV_TEMP_LO && i <= EV_TEMP_HI) begin
      base = 32'(TEMP_CYC);
    end
    deb_limit = base;
  endfunction

  // Whether a debounced transition of event i sets its flag.
  function automatic logic fires(input int i, input logic rise);
    fires = rise || i == EV_BUTTON || (i >= EV_TEMP_LO && i <= EV_TEMP_HI);
  endfunction

  // --------------------------------------------------------------------
  // Synchroniser and debounce.
  // --------------------------------------------------------------------
  // A level counts once the second and third stages agree.
  always_comb begin
    lvl_nxt  = lvl_r;
    seen_nxt = seen_r;
    deb_nxt  = deb_r;
    set_ev   = '0;
    // One more stage of ones each edge; full once the third stage holds a pin sample.
    warm_nxt = {warm_r[1:0], 1'b1};
    for (int i = 0; i < NUM_IN; i++) begin
      if (s2_r[i] == s3_r[i]) begin
        lvl_nxt[i] = s3_r[i];
      end
    end
    // Second pass: time each event's stability against its limit.
    for (int i = 0; i < NUM_EV; i++) begin
      // Counters idle at zero whenever the level agrees.
      cnt_nxt[i] = '0;
      // Reset-state stages would otherwise look settled and turn a pin held high into an event.
      if (s2_r[i] == s3_r[i] && warm_r[2]) begin
        seen_nxt[i] = 1'b1;
      end
      if (!seen_r[i]) begin
        // Adopt the first settled level quietly so reset raises no event.
        deb_nxt[i] = lvl_nxt[i];
      end else if (lvl_r[i] != deb_r[i]) begin
        // Level differs from the accepted one: time its stability.
        if (cnt_r[i] >= deb_limit(i, lvl_r[i], button_debounce_sel) - 32'd1) begin
          deb_nxt[i] = lvl_r[i];
          set_ev[i]  = fires(i, lvl_r[i]);
        end else begin
          cnt_nxt[i] = cnt_r[i] + 32'd1;
        end
      end
    end
  end

  // Registers the synchroniser, levels and debounce state.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_r   <= '0;
      s2_r   <= '0;
      s3_r   <= '0;
      lvl_r  <= '0;
      seen_r <= '0;
      deb_r  <= '0;
      warm_r <= '0;
      for (int i = 0; i < NUM_EV; i++) begin
        cnt_r[i] <= '0;
      end
    end else begin
      s1_r   <= raw;
      s2_r   <= s1_r;
      s3_r   <= s2_r;
      lvl_r  <= lvl_nxt;
      seen_r <= seen_nxt;
      deb_r  <= deb_nxt;
      warm_r <= warm_nxt;
      for (int i = 0; i < NUM_EV; i++) begin
        cnt_r[i] <= cnt_nxt[i];
      end
    end
  end

  // --------------------------------------------------------------------
  // Register file and interrupt pin.
  // --------------------------------------------------------------------
  // Applies writes, latches events and forms read data and the pin.
  always_comb begin
    logic [NUM_EV-1:0] clr;
    clr       = '0;
    mk_nxt    = mk_r;
    mkrsv_nxt = mkrsv_r;
    rdata_nxt = rdata_r;
    // Writes: status bits clear on a one, masks load, other offsets are ignored.
    if (reg_req.wr_en) begin
      case (reg_req.addr)
        EVENT_STATUS_A_OFS: clr[EV_TEMP_HI:0] = reg_req.wdata[5:0];
        EVENT_MASK_A_OFS: begin
          mk_nxt[EV_TEMP_HI:0] = reg_req.wdata[5:0];
        end
        EVENT_STATUS_B_OFS: clr[EV_BOOST-1:EV_BUCK_LO] = unpack_b(reg_req.wdata);
        EVENT_MASK_B_OFS: begin
          mk_nxt[EV_BOOST-1:EV_BUCK_LO] = unpack_b(reg_req.wdata);
          mkrsv_nxt = {reg_req.wdata[6], reg_req.wdata[2]};
        end
        EVENT_STATUS_C_OFS: begin
          clr[EV_BOOST] = reg_req.wdata[0];
          clr[EV_FUSE]  = reg_req.wdata[FUSE_BIT];
        end
        EVENT_MASK_C_OFS: begin
          mk_nxt[EV_BOOST] = reg_req.wdata[0];
          mk_nxt[EV_FUSE]  = reg_req.wdata[FUSE_BIT];
        end
        EVENT_STATUS_D_OFS: clr[EV_LDO_ONE] = reg_req.wdata[0];
        EVENT_MASK_D_OFS:   mk_nxt[EV_LDO_ONE] = reg_req.wdata[0];
        default: clr = '0;  // Other offsets belong elsewhere; ignored.
      endcase
    end
    // A new event in the clearing cycle keeps its flag; flags latch regardless of mask.
    st_nxt = (st_r & ~clr) | set_ev;
    // Reads: the byte lands in the data register on the strobe's edge and then holds.
    if (reg_req.rd_en) begin
      case (reg_req.addr)
        EVENT_STATUS_A_OFS: rdata_nxt = {2'b00, st_r[EV_TEMP_HI:0]};
        EVENT_MASK_A_OFS:   rdata_nxt = {2'b00, mk_r[EV_TEMP_HI:0]};
        EVENT_LEVEL_A_OFS:  rdata_nxt = {lvl_r[IN_PROG_SUP], 1'b0, lvl_r[EV_TEMP_HI:0]};
        EVENT_STATUS_B_OFS: rdata_nxt = pack_b(st_r[EV_BOOST-1:EV_BUCK_LO]);
        EVENT_MASK_B_OFS: begin
          rdata_nxt    = pack_b(mk_r[EV_BOOST-1:EV_BUCK_LO]);
          rdata_nxt[2] = mkrsv_r[0];
          rdata_nxt[6] = mkrsv_r[1];
        end
        EVENT_LEVEL_B_OFS:  rdata_nxt = pack_b(lvl_r[EV_BOOST-1:EV_BUCK_LO]);
        EVENT_STATUS_C_OFS: rdata_nxt = {st_r[EV_FUSE], 6'h00, st_r[EV_BOOST]};
        EVENT_MASK_C_OFS:   rdata_nxt = {mk_r[EV_FUSE], 6'h00, mk_r[EV_BOOST]};
        EVENT_LEVEL_C_OFS:  rdata_nxt = {lvl_r[EV_FUSE], 6'h00, lvl_r[EV_BOOST]};
        EVENT_STATUS_D_OFS: rdata_nxt = {7'h00, st_r[EV_LDO_ONE]};
        EVENT_MASK_D_OFS:   rdata_nxt = {7'h00, mk_r[EV_LDO_ONE]};
        EVENT_LEVEL_D_OFS:  rdata_nxt = {7'h00, lvl_r[EV_LDO_ONE]};
        default:            rdata_nxt = 8'h00;  // Unmapped offsets read zero.
      endcase
    end
    // Pin is low while any unmasked flag is pending.
    irq_n_nxt = ~|(st_nxt & ~mk_nxt);
  end

  // Registers flags, masks, read data and the interrupt pin.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r    <= STATUS_RST;
      mk_r    <= MASK_RST;
      mkrsv_r <= MASK_B_RSV_RST;
      rdata_r <= 8'h00;
      irq_n_r <= 1'b1;
    end else begin
      st_r    <= st_nxt;
      mk_r    <= mk_nxt;
      mkrsv_r <= mkrsv_nxt;
      rdata_r <= rdata_nxt;
      irq_n_r <= irq_n_nxt;
    end
  end

  // Both outputs come straight from flip-flops.
  assign reg_rdata = rdata_r;
  assign irq_out_n = irq_n_r;

endmodule

// ===== bench/event_irq_ctrl_chk.sv
// ----------------------------------------------------------------------
// Port checker for the event interrupt block.
// ----------------------------------------------------------------------
module event_irq_ctrl_chk (
  input wire logic                     clk,
  input wire logic                     rst_b,
  input wire event_irq_pkg::event_in_t ev_in,
  input wire logic [1:0]               button_debounce_sel,
  input wire event_irq_pkg::reg_req_t  reg_req,
  input wire logic [7:0]               reg_rdata,
  input wire logic                     irq_out_n
);
  timeunit 1ns;
  timeprecision 100ps;
  import event_irq_pkg::*;
  logic       rd;           // Read strobe.
  logic [7:0] ad;           // Request address.
  logic       wr06;         // Write to mask A.
  logic       wr09;         // Write to mask B.
  logic       seen_wr_r;    // A write was taken since reset.
  logic       seen_wr_nxt;  // Next value of the write marker.
  assign rd = reg_req.rd_en;
  assign ad = reg_req.addr;
  assign wr06 = reg_req.wr_en && ad == 8'h06;
  assign wr09 = reg_req.wr_en && ad == 8'h09;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // The marker rises on the first write and then holds.
  always_comb seen_wr_nxt = seen_wr_r | reg_req.wr_en;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) seen_wr_r <= 1'b0;
    else seen_wr_r <= seen_wr_nxt;
  end
  a_start_masked: assert property (!seen_wr_r |-> irq_out_n)
    else $error("interrupt while all masked");
  a_unmapped_zero: assert property ((rd && (ad < 8'h05 || ad > 8'h13
    || (ad > 8'h0A && ad < 8'h0E))) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_status_a_unused: assert property (rd && ad == 8'h05 |=> reg_rdata[7:6] == 2'h0)
    else $error("status a unused bits set");
  a_status_b_rsvd: assert property (rd && ad == 8'h08 |=> reg_rdata[7:6] == 2'h0 && !reg_rdata[2])
    else $error("status b reserved bits set");
  a_mask_a_rw: assert property (rd && ad == 8'h06 && !$past(reg_req.wr_en) && $past(wr06, 2)
    |=> reg_rdata == ($past(reg_req.wdata, 3) & 8'h3F))
    else $error("mask a read back wrong");
  a_mask_b_rw: assert property (rd && ad == 8'h09 && !$past(reg_req.wr_en) && $past(wr09, 2)
    |=> reg_rdata == ($past(reg_req.wdata, 3) & 8'h7F))
    else $error("mask b read back wrong");
  a_level_a_live: assert property ($stable(ev_in) [*8] ##0 (rd && ad == 8'h07)
    |=> reg_rdata == {$past(ev_in.prog_supply_pin), 1'b0, $past(ev_in.temp_trip),
                      !$past(ev_in.supply_ok), $past(ev_in.power_button_in)})
    else $error("level a wrong");
  a_level_b_live: assert property ($stable(ev_in) [*8] ##0 (rd && ad == 8'h0A)
    |=> reg_rdata == {2'h0, $past(ev_in.buck_oc[4:2]), 1'b0, $past(ev_in.buck_oc[1:0])})
    else $error("level b wrong");
  a_level_c_live: assert property ($stable(ev_in) [*8] ##0 (rd && ad == 8'h10)
    |=> reg_rdata == {$past(ev_in.fuse_error), 6'h00, $past(ev_in.boost_oc)})
    else $error("level c wrong");
endmodule
bind event_irq_ctrl event_irq_ctrl_chk chk_inst (.clk, .rst_b, .ev_in, .button_debounce_sel,
  .reg_req, .reg_rdata, .irq_out_n);

// ===== bench/host_model.sv
// ----------------------------------------------------------------------
// Host side of the register port: single byte strobes.
// ----------------------------------------------------------------------
module host_model (
  input  wire logic               clk,
  output event_irq_pkg::reg_req_t reg_req,
  input  wire logic [7:0]         reg_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  import event_irq_pkg::*;
  initial reg_req = '0;  // Idle port at time zero.
  // Write one byte; released address and data are inverted.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_req <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    reg_req <= '{1'b0, 1'b0, ~a, ~d};
  endtask
  // Poll one register; data is taken one cycle after the strobe.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_req <= '{1'b0, 1'b1, a, 8'h5A};
    @(posedge clk);
    reg_req <= '{1'b0, 1'b0, ~a, 8'hA5};
    #1 d = reg_rdata;
  endtask
endmodule

// ===== bench/tb_event_irq_ctrl.sv
module tb_event_irq_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  import event_irq_pkg::*;
  // --------------------------------------------------------------------
  // Short debounce counts keep the run brief.
  // --------------------------------------------------------------------
  localparam int LOWV = 20;
  localparam int BTN = 40;
  localparam int TEMP = 20;
  localparam int OC = 30;
  localparam logic [7:0] ST_A [4] = '{8'h05, 8'h08, 8'h0E, 8'h11};  // Status registers.
  localparam logic [7:0] MK_A [4] = '{8'h06, 8'h09, 8'h0F, 8'h12};  // Mask registers.
  localparam logic [7:0] RS_A [7] = '{8'h05, 8'h06, 8'h08, 8'h09, 8'h00, 8'h0B, 8'h14};
  localparam logic [7:0] RS_V [7] = '{8'h00, 8'h3F, 8'h00, 8'h7F, 8'h00, 8'h00, 8'h00};
  logic        clk = 1'b0;
  logic        rst_b;
  event_in_t   ev_in;
  logic [1:0]  sel;
  reg_req_t    reg_req;
  logic [7:0]  reg_rdata, d;
  logic        irq_out_n, v, e, g, unm;
  logic [4:0]  l;                     // Status group and bit of the event.
  logic [31:0] seed = 32'h7A831923;
  int          failures, num_checks, cyc, i, n;
  event_irq_ctrl #(.LOWV_CYC(LOWV), .BTN_CYC(BTN), .TEMP_CYC(TEMP), .OC_CYC(OC))
    event_irq_ctrl_inst (.clk, .rst_b, .ev_in, .button_debounce_sel(sel), .reg_req,
                         .reg_rdata, .irq_out_n);
  host_model host_model_inst (.clk, .reg_req, .reg_rdata);
  always #2.5 clk = ~clk;  // 200 MHz clock.
  // A hang counts as a mismatch.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      failures++;
      stop_test();
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // Where each event latches its flag.
  function automatic logic [4:0] ev_loc(input int k);
    if (k < 6) return {2'h0, 3'(k)};
    if (k < 8) return {2'h1, 3'(k - 6)};
    if (k < 11) return {2'h1, 3'(k - 5)};
    if (k == 11) return 5'h10;
    return (k == 12) ? 5'h17 : 5'h18;
  endfunction
  // Whether a new level x of input k is a latching edge.
  function automatic logic trig(input int k, input logic x);
    if (k == 1) return !x;
    return (k < 6) || x;
  endfunction
  // Debounce length; falling button and supply scale with the select.
  function automatic int deb(input int k, input logic x, input logic [1:0] s);
    if (k == 0) return x ? BTN : BTN << s;
    if (k == 1) return x ? LOWV : LOWV << s;
    return (k < 6) ? TEMP : OC;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    ev_in = '0;
    ev_in.supply_ok = 1'b1;
    ev_in.power_button_in = 1'b1;  // Button idles high; reset must not treat it as an edge.
    sel = 2'h0;
    rst_b = 1'b0;
    unm = 1'b0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    for (int k = 0; k < 7; k++) begin
      host_model_inst.rd(RS_A[k], d);
      chk(d, RS_V[k], "reset value");
    end
    host_model_inst.wr(8'h06, 8'hFF);
    host_model_inst.rd(8'h06, d);
    chk(d, 8'h3F, "mask a");
    host_model_inst.wr(8'h09, 8'hFF);
    host_model_inst.rd(8'h09, d);
    chk(d, 8'h7F, "mask b");
    host_model_inst.wr(8'h07, 8'hFF);
    host_model_inst.rd(8'h07, d);
    chk(d, {ev_in[14], 1'b0, ev_in[5:2], ~ev_in[1], ev_in[0]}, "level a read only");
    $display("test registers done");
    // A buck overload that lands on the very edge of a clear keeps its flag.
    @(posedge clk);
    ev_in.buck_oc[0] <= 1'b1;
    repeat (OC + 2) @(posedge clk);
    host_model_inst.wr(8'h08, 8'hFF);
    host_model_inst.rd(8'h08, d);
    chk(d, 8'h01, "set beats clear");
    @(posedge clk);
    ev_in.buck_oc[0] <= 1'b0;
    repeat (OC + 8) @(posedge clk);
    host_model_inst.rd(8'h08, d);
    chk(d, 8'h01, "flag held after source drops");
    host_model_inst.wr(8'h08, 8'h01);
    host_model_inst.rd(8'h08, d);
    chk(d, 8'h00, "flag cleared");
    $display("test corner done");
    // Random event edges, some cut short as glitches.
    for (int it = 0; it < 40; it++) begin
      seed = xs(seed);
      i = int'(seed[7:0] % 8'h0E);
      l = ev_loc(i);
      v = ~ev_in[i];
      g = seed[9];
      e = trig(i, v) & !g;
      n = deb(i, v, seed[11:10]);
      @(posedge clk);
      sel <= seed[11:10];
      ev_in[i] <= v;
      ev_in[14] <= seed[8];
      if (g) begin
        repeat (5) @(posedge clk);
        ev_in[i] <= ~v;
      end
      repeat (n - 4) @(posedge clk);
      host_model_inst.rd(ST_A[l[4:3]], d);
      chk(d, 8'h00, "early flag");
      repeat (16) @(posedge clk);
      host_model_inst.wr(ST_A[l[4:3]], 8'h00);
      if (e && !unm && it > 9) begin
        unm = 1'b1;
        for (int k = 0; k < 4; k++) host_model_inst.wr(MK_A[k], 8'h00);
      end
      #1 chk({7'h0, irq_out_n}, {7'h0, !(e && unm)}, "irq level");
      for (int k = 0; k < 4; k++) begin
        host_model_inst.rd(ST_A[k], d);
        chk(d, (e && k == l[4:3]) ? 8'h01 << l[2:0] : 8'h00, "flag");
      end
      host_model_inst.rd(8'h07, d);
      chk(d, {ev_in[14], 1'b0, ev_in[5:2], ~ev_in[1], ev_in[0]}, "level a");
      host_model_inst.rd(8'h0A, d);
      chk(d, {2'h0, ev_in[10:8], 1'b0, ev_in[7:6]}, "level b");
      host_model_inst.rd(8'h10, d);
      chk(d, {ev_in[12], 6'h00, ev_in[11]}, "level c");
      host_model_inst.rd(8'h13, d);
      chk(d, {7'h00, ev_in[13]}, "level d");
      host_model_inst.wr(ST_A[l[4:3]], 8'hFF);
      #1 chk({7'h0, irq_out_n}, 8'h01, "irq release");
    end
    $display("test events done");
    stop_test();
  end
endmodule
